// [design/cbf_regs.svh]
// Function
// - wake detection uses the line filter when enabled, else bypasses it
// - phase two length is field value plus one quanta
// - phase two is programmed when selected, else max of phase one and IPT
// - sample line three times at sample point when set, else once
// - phase one length is field value plus one quanta
// - phase two not limited to phase one; programmed value used as is, derived automatically when not selected
// - bit timing writes taken only in configuration mode 100
// - timing bits 31 to 23 and 21 to 19 read as zero
// - a filter takes part in matching only while enabled
// - each filter applies the mask chosen by its mask select field
// - accepted message goes to the fifo numbered by fifo select
// - filter byte holds enable, mask select, fifo select; 11 on top
// - mask and fifo select writable only while filter enable is zero
// - requested mode 100 enters configuration, reported once entered
`ifndef CBF_REGS_SVH
`define CBF_REGS_SVH

// register byte addresses
`define CBF_ADDR_CTRL 8'h00
`define CBF_ADDR_TIMING 8'h04
`define CBF_ADDR_FILTER 8'h08

// control register fields
`define CBF_CT_REQ 26:24
`define CBF_CT_CUR 23:21

// bit timing register fields
`define CBF_TM_WAKE 22
`define CBF_TM_PH2 18:16
`define CBF_TM_FREE 15
`define CBF_TM_TRIPLE 14
`define CBF_TM_PH1 13:11
`define CBF_TM_PROP 10:8
`define CBF_TM_SJW 7:6
`define CBF_TM_PRESC 5:0

// filter control: one byte per filter, first filter number
`define CBF_FLT_FIRST 4'h8
`define CBF_FLT_ON 7
`define CBF_FLT_MASK 6:5
`define CBF_FLT_FIFO 4:0

// mode codes and reset values
`define CBF_MODE_CONFIG 3'h4
`define CBF_MODE_RSVD_A 3'h5
`define CBF_MODE_RSVD_B 3'h6
`define CBF_RST_MODE 3'h4
`define CBF_RST_TIMING 20'h0_0000
`define CBF_RST_FILTER 8'h00

// timing counts
`define CBF_IPT_QUANTA 4'h2
`define CBF_WAKE_FILT_CYCLES 4'h8

`endif

// [design/cbf_pkg.sv]
package cbf_pkg;

  typedef struct packed {
    logic wakeLineFilterEn;
    logic [2:0] phaseTwoLength;
    logic phaseTwoFreeSelect;
    logic tripleBitSampling;
    logic [2:0] phaseOneLength;
    logic [2:0] propSegLength;
    logic [1:0] resyncJumpWidth;
    logic [5:0] prescalerValue;
  } cbf_timing_t;

  typedef struct packed {
    logic filterOn;
    logic [1:0] maskChoice;
    logic [4:0] fifoTarget;
  } cbf_filter_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wrData;
    logic wrStb;
    logic rdStb;
  } cbf_bus_req_t;

  typedef enum logic [1:0] {
    SEG_SYNC,
    SEG_PROP,
    SEG_PH1,
    SEG_PH2
  } cbf_seg_t;

endpackage

// [design/cbf_line_sync.sv]
`timescale 1ns/1ps
`include "cbf_regs.svh"
module cbf_line_sync import cbf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line pin and setup
  input wire logic canRx,
  input wire logic wakeLineFilterEn,
  // conditioned line and wake event
  output logic rxLevel,
  output logic wakeEvent
);

  logic sync1_ff, sync2_ff, sync3_ff;
  logic rxLevel_ff, nxt_rxLevel;
  logic [3:0] lowCnt_ff, nxt_lowCnt;
  logic wakeEvent_ff, nxt_wakeEvent;
  wire rawFall;
  wire filtHit;

  // level accepted once second and third stages agree
  assign nxt_rxLevel = (sync2_ff == sync3_ff) ? sync3_ff : rxLevel_ff;
  assign rawFall = rxLevel_ff & ~nxt_rxLevel;
  assign filtHit = ~rxLevel_ff &
    (lowCnt_ff == `CBF_WAKE_FILT_CYCLES - 4'h1);
  assign nxt_lowCnt = rxLevel_ff ? 4'h0 :
    (lowCnt_ff == `CBF_WAKE_FILT_CYCLES) ? lowCnt_ff : lowCnt_ff + 4'h1;
  assign nxt_wakeEvent = wakeLineFilterEn ? filtHit : rawFall;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      rxLevel_ff <= 1'b1;
      lowCnt_ff <= 4'h0;
      wakeEvent_ff <= 1'b0;
    end else begin
      sync1_ff <= canRx;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      rxLevel_ff <= nxt_rxLevel;
      lowCnt_ff <= nxt_lowCnt;
      wakeEvent_ff <= nxt_wakeEvent;
    end
  end

  assign rxLevel = rxLevel_ff;
  assign wakeEvent = wakeEvent_ff;

endmodule

// [design/cbf_bit_timer.sv]
`timescale 1ns/1ps
`include "cbf_regs.svh"
module cbf_bit_timer import cbf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // segment setup
  input wire cbf_timing_t cfg,
  input wire logic [3:0] phaseTwoLen,
  // quantum and bit events
  output logic quantumTick,
  output logic samplePoint,
  output logic bitEnd
);

  cbf_seg_t seg_ff, nxt_seg;
  logic [6:0] prescCnt_ff, nxt_prescCnt;
  logic [3:0] segCnt_ff, nxt_segCnt;
  logic [3:0] segLen;
  logic quantumTick_ff, samplePoint_ff, bitEnd_ff;
  wire tqLast;
  wire segLast;

  assign tqLast = prescCnt_ff == {1'b0, cfg.prescalerValue};
  assign nxt_prescCnt = tqLast ? 7'h00 : prescCnt_ff + 7'h01;
  assign segLast = tqLast & (segCnt_ff == segLen - 4'h1);
  assign nxt_segCnt = segLast ? 4'h0 :
    tqLast ? segCnt_ff + 4'h1 : segCnt_ff;

  // segment lengths in quanta
  always_comb begin
    nxt_seg = seg_ff;
    segLen = 4'h1;
    case (seg_ff)
      SEG_SYNC: begin
        segLen = 4'h1;
        if (segLast) nxt_seg = SEG_PROP;
      end
      SEG_PROP: begin
        segLen = {1'b0, cfg.propSegLength} + 4'h1;
        if (segLast) nxt_seg = SEG_PH1;
      end
      SEG_PH1: begin
        segLen = {1'b0, cfg.phaseOneLength} + 4'h1;
        if (segLast) nxt_seg = SEG_PH2;
      end
      SEG_PH2: begin
        segLen = phaseTwoLen;
        if (segLast) nxt_seg = SEG_SYNC;
      end
      default: begin
        segLen = 4'h1;
        nxt_seg = SEG_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seg_ff <= SEG_SYNC;
      prescCnt_ff <= 7'h00;
      segCnt_ff <= 4'h0;
      quantumTick_ff <= 1'b0;
      samplePoint_ff <= 1'b0;
      bitEnd_ff <= 1'b0;
    end else begin
      seg_ff <= nxt_seg;
      prescCnt_ff <= nxt_prescCnt;
      segCnt_ff <= nxt_segCnt;
      quantumTick_ff <= tqLast;
      samplePoint_ff <= segLast & (seg_ff == SEG_PH1);
      bitEnd_ff <= segLast & (seg_ff == SEG_PH2);
    end
  end

  assign quantumTick = quantumTick_ff;
  assign samplePoint = samplePoint_ff;
  assign bitEnd = bitEnd_ff;

endmodule

// [design/cbf_top.sv]
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cbf_regs.svh"
module cbf_top import cbf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire cbf_bus_req_t busReq,
  output logic [31:0] rdData,
  // can line
  input wire logic canRx,
  // match engine
  input wire logic hitValid,
  input wire logic [3:0] filterHit,
  // bit timing outputs
  output logic sampledBit,
  output logic sampleStrobe,
  output logic bitBoundary,
  output logic wakeEvent,
  output logic [3:0] phaseTwoEff,
  // mode and filter outputs
  output logic [2:0] currentOpState,
  output logic [3:0] filterOn,
  output logic [7:0] maskChoice,
  output logic [19:0] fifoTarget,
  output logic storeValid,
  output logic [4:0] storeFifo,
  output logic [1:0] storeMask,
  output logic [3:0] storeFilter
);

  // lowest enabled hit, index plus found flag
  function automatic logic [2:0] firstHit(input logic [3:0] hits);
    logic [2:0] res;
    res = 3'h0;
    for (int k = 3; k >= 0; k--) begin
      if (hits[k]) res = {1'b1, 2'(k)};
    end
    return res;
  endfunction

  // mode codes that are not entered
  function automatic logic isReserved(input logic [2:0] mode);
    return (mode == `CBF_MODE_RSVD_A) || (mode == `CBF_MODE_RSVD_B);
  endfunction

  function automatic logic majority3(input logic a, input logic b,
                                     input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  cbf_timing_t timing_ff;
  cbf_filter_t filter_ff [3:0];
  logic [2:0] reqMode_ff;
  logic [2:0] curMode_ff, nxt_curMode;
  logic [31:0] rdData_ff, nxt_rdData;
  logic [3:0] phaseTwoEff_ff, nxt_phaseTwoEff;
  logic [1:0] hist_ff;
  logic sampledBit_ff, nxt_sampledBit;
  logic storeValid_ff;
  logic [4:0] storeFifo_ff;
  logic [1:0] storeMask_ff;
  logic [3:0] storeFilter_ff;
  logic rxLevel;
  logic quantumTick;
  logic samplePoint;
  logic bitEnd;

  wire selCtrl;
  wire selTiming;
  wire selFilter;
  wire inConfig;
  wire wrTiming;
  wire wrFilter;
  wire [31:0] ctrlWord;
  wire [31:0] timingWord;
  wire [31:0] filterWord;
  wire [3:0] phaseOneQuanta;
  wire [3:0] phaseTwoQuanta;
  wire [3:0] enabledHits;
  wire [2:0] pick;
  wire modeStep;

  // address decode
  assign selCtrl = busReq.addr == `CBF_ADDR_CTRL;
  assign selTiming = busReq.addr == `CBF_ADDR_TIMING;
  assign selFilter = busReq.addr == `CBF_ADDR_FILTER;
  assign inConfig = curMode_ff == `CBF_MODE_CONFIG;
  assign wrTiming = busReq.wrStb & selTiming & inConfig;
  assign wrFilter = busReq.wrStb & selFilter;

  // read words
  assign ctrlWord = {5'h00, reqMode_ff, curMode_ff, 21'h00_0000};
  assign timingWord = {9'h000, timing_ff.wakeLineFilterEn, 3'h0,
    timing_ff.phaseTwoLength, timing_ff.phaseTwoFreeSelect,
    timing_ff.tripleBitSampling, timing_ff.phaseOneLength,
    timing_ff.propSegLength, timing_ff.resyncJumpWidth,
    timing_ff.prescalerValue};
  assign filterWord = {filter_ff[3], filter_ff[2], filter_ff[1],
    filter_ff[0]};
  assign nxt_rdData = !busReq.rdStb ? 32'h0000_0000 :
    selCtrl ? ctrlWord :
    selTiming ? timingWord :
    selFilter ? filterWord : 32'h0000_0000;

  // effective phase two length
  assign phaseOneQuanta = {1'b0, timing_ff.phaseOneLength} + 4'h1;
  assign phaseTwoQuanta = {1'b0, timing_ff.phaseTwoLength} + 4'h1;
  assign nxt_phaseTwoEff = timing_ff.phaseTwoFreeSelect ? phaseTwoQuanta :
    (phaseOneQuanta > `CBF_IPT_QUANTA) ? phaseOneQuanta :
    `CBF_IPT_QUANTA;

  // sample point value, single or majority of three quanta
  assign nxt_sampledBit = !samplePoint ? sampledBit_ff :
    timing_ff.tripleBitSampling ?
    majority3(hist_ff[1], hist_ff[0], rxLevel) : rxLevel;

  // mode tracking, config left at once, entered at a bit boundary
  assign modeStep = (curMode_ff != reqMode_ff) &&
    !isReserved(reqMode_ff) && (inConfig || bitEnd);
  assign nxt_curMode = modeStep ? reqMode_ff : curMode_ff;

  // acceptance
  assign enabledHits = {filter_ff[3].filterOn, filter_ff[2].filterOn,
    filter_ff[1].filterOn, filter_ff[0].filterOn} & filterHit;
  assign pick = firstHit(enabledHits);

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_ff <= 32'h0000_0000;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reqMode_ff <= `CBF_RST_MODE;
      curMode_ff <= `CBF_RST_MODE;
    end else begin
      if (busReq.wrStb && selCtrl) begin
        reqMode_ff <= busReq.wrData[`CBF_CT_REQ];
      end
      curMode_ff <= nxt_curMode;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timing_ff <= `CBF_RST_TIMING;
    end else if (wrTiming) begin
      timing_ff.wakeLineFilterEn <= busReq.wrData[`CBF_TM_WAKE];
      timing_ff.phaseTwoLength <= busReq.wrData[`CBF_TM_PH2];
      timing_ff.phaseTwoFreeSelect <= busReq.wrData[`CBF_TM_FREE];
      timing_ff.tripleBitSampling <= busReq.wrData[`CBF_TM_TRIPLE];
      timing_ff.phaseOneLength <= busReq.wrData[`CBF_TM_PH1];
      timing_ff.propSegLength <= busReq.wrData[`CBF_TM_PROP];
      timing_ff.resyncJumpWidth <= busReq.wrData[`CBF_TM_SJW];
      timing_ff.prescalerValue <= busReq.wrData[`CBF_TM_PRESC];
    end
  end

  // filter bytes, 8 to 11 from low byte up
  for (genvar i = 0; i < 4; i++) begin : gFilt
    wire [7:0] wrByte = busReq.wrData[8*i +: 8];
    always_ff @(posedge clk) begin
      if (rst) begin
        filter_ff[i] <= `CBF_RST_FILTER;
      end else if (wrFilter) begin
        filter_ff[i].filterOn <= wrByte[`CBF_FLT_ON];
        if (!filter_ff[i].filterOn) begin
          filter_ff[i].maskChoice <= wrByte[`CBF_FLT_MASK];
          filter_ff[i].fifoTarget <= wrByte[`CBF_FLT_FIFO];
        end
      end
    end
    assign maskChoice[2*i +: 2] = filter_ff[i].maskChoice;
    assign fifoTarget[5*i +: 5] = filter_ff[i].fifoTarget;
    assign filterOn[i] = filter_ff[i].filterOn;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phaseTwoEff_ff <= 4'h1;
      hist_ff <= 2'h3;
      sampledBit_ff <= 1'b1;
    end else begin
      phaseTwoEff_ff <= nxt_phaseTwoEff;
      if (quantumTick) begin
        hist_ff <= {hist_ff[0], rxLevel};
      end
      sampledBit_ff <= nxt_sampledBit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      storeValid_ff <= 1'b0;
      storeFifo_ff <= 5'h00;
      storeMask_ff <= 2'h0;
      storeFilter_ff <= 4'h0;
    end else begin
      storeValid_ff <= hitValid & pick[2];
      if (hitValid && pick[2]) begin
        storeFifo_ff <= filter_ff[pick[1:0]].fifoTarget;
        storeMask_ff <= filter_ff[pick[1:0]].maskChoice;
        storeFilter_ff <= `CBF_FLT_FIRST + {2'h0, pick[1:0]};
      end
    end
  end

  cbf_line_sync uLine (
    .clk(clk),
    .rst(rst),
    .canRx(canRx),
    .wakeLineFilterEn(timing_ff.wakeLineFilterEn),
    .rxLevel(rxLevel),
    .wakeEvent(wakeEvent)
  );

  cbf_bit_timer uTimer (
    .clk(clk),
    .rst(rst),
    .cfg(timing_ff),
    .phaseTwoLen(phaseTwoEff_ff),
    .quantumTick(quantumTick),
    .samplePoint(samplePoint),
    .bitEnd(bitEnd)
  );

  assign rdData = rdData_ff;
  assign sampledBit = sampledBit_ff;
  assign sampleStrobe = samplePoint;
  assign bitBoundary = bitEnd;
  assign phaseTwoEff = phaseTwoEff_ff;
  assign currentOpState = curMode_ff;
  assign storeValid = storeValid_ff;
  assign storeFifo = storeFifo_ff;
  assign storeMask = storeMask_ff;
  assign storeFilter = storeFilter_ff;

endmodule

// [testbench/cbf_top_asserts.sv]
`timescale 1ns/1ps
module cbf_checker import cbf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire cbf_bus_req_t busReq,
  input wire logic [31:0] rdData,
  input wire logic hitValid,
  input wire logic [3:0] filterHit,
  input wire logic sampleStrobe,
  input wire logic bitBoundary,
  input wire logic [3:0] phaseTwoEff,
  input wire logic [2:0] currentOpState,
  input wire logic [3:0] filterOn,
  input wire logic [7:0] maskChoice,
  input wire logic [19:0] fifoTarget,
  input wire logic storeValid,
  input wire logic [4:0] storeFifo,
  input wire logic [3:0] storeFilter
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // enabled filters among the hits
  wire logic [3:0] live = filterHit & filterOn;
  rsvd_zero_a: assert property ($past(busReq.rdStb) &&
    $past(busReq.addr) == 8'h04 |-> rdData[31:23] == 9'h000 &&
    rdData[21:19] == 3'h0) else $error("timing spare bits set");
  store_fire_a: assert property (
    storeValid == $past(hitValid && (|live)))
    else $error("store pulse wrong");
  store_fifo_a: assert property (storeValid |->
    storeFifo == 5'($past(fifoTarget) >> (5 * storeFilter[1:0])))
    else $error("store fifo wrong");
  lowest_win_a: assert property (storeValid |-> storeFilter[3] &&
    ($past(live) & ((4'h2 << storeFilter[1:0]) - 4'h1)) ==
    (4'h1 << storeFilter[1:0])) else $error("wrong winner");
  timing_lock_a: assert property ($past(currentOpState, 3) != 3'h4 &&
    $past(currentOpState, 2) != 3'h4 && $past(currentOpState) != 3'h4
    |-> $stable(phaseTwoEff)) else $error("timing changed");
  mode_step_a: assert property ($changed(currentOpState) &&
    $past(currentOpState) != 3'h4 |-> $past(bitBoundary))
    else $error("mode moved off boundary");
  fltr_lock_a: assert property (filterOn[3] && $past(filterOn[3])
    |-> $stable(fifoTarget[19:15]) && $stable(maskChoice[7:6]))
    else $error("locked filter changed");
  bit_end_a: assert property (sampleStrobe |->
    !bitBoundary ##[1:1000] bitBoundary) else $error("no bit end");
endmodule

// [testbench/cbf_node_model.sv]
`timescale 1ns/1ps
module cbf_node_model (
  // clock
  input wire logic clk,
  // dominant burst request
  input wire logic start,
  input wire logic [7:0] lowLen,
  // line from the transceiver
  output logic canRx
);
  logic [7:0] cnt = 8'h00;
  // idles recessive, dominant for lowLen cycles per start
  always @(posedge clk) begin
    if (start)
      cnt <= lowLen;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  assign canRx = (cnt == 8'h00);
endmodule

// [testbench/cbf_top_tb.sv]
`timescale 1ns/1ps
module cbf_top_tb;
  logic clk, rst, hitValid, start, canRx;
  logic sampledBit, sampleStrobe, bitBoundary, wakeEvent, storeValid;
  logic [3:0] filterHit, phaseTwoEff, filterOn, storeFilter;
  logic [7:0] lowLen, maskChoice;
  logic [31:0] rdData, rv;
  logic [2:0] currentOpState;
  logic [19:0] fifoTarget;
  logic [4:0] storeFifo;
  logic [1:0] storeMask;
  cbf_pkg::cbf_bus_req_t busReq;
  int failures = 0, nChecks = 0, cyc = 0, n;
  cbf_top dut (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .canRx(canRx), .hitValid(hitValid), .filterHit(filterHit),
    .sampledBit(sampledBit), .sampleStrobe(sampleStrobe),
    .bitBoundary(bitBoundary), .wakeEvent(wakeEvent),
    .phaseTwoEff(phaseTwoEff), .currentOpState(currentOpState),
    .filterOn(filterOn), .maskChoice(maskChoice), .fifoTarget(fifoTarget),
    .storeValid(storeValid), .storeFifo(storeFifo), .storeMask(storeMask),
    .storeFilter(storeFilter));
  cbf_node_model node (.clk(clk), .start(start), .lowLen(lowLen),
    .canRx(canRx));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq.wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    busReq.rdStb <= 1'b0;
    #1 rv = rdData;
  endtask
  task automatic waitHigh(input logic pickStrobe, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while ((pickStrobe ? sampleStrobe : bitBoundary) !== 1'b1 &&
      k < 2000);
  endtask
  task automatic waitMode(input logic [2:0] m);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (currentOpState !== m && n < 200);
  endtask
  task automatic t_reset;
    rd(8'h00);
    chk(rv, 32'h0480_0000);
    rd(8'h04);
    chk(rv, 32'h0000_0000);
    rd(8'h08);
    chk(rv, 32'h0000_0000);
    rd(8'h0C);
    chk(rv, 32'h0000_0000);
    chk(phaseTwoEff, 4'h2);
  endtask
  task automatic t_timing;
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04);
    chk(rv, 32'h0047_FFFF);
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 32'h0000_B800 | (i << 16));
      @(posedge clk);
      #1 chk(phaseTwoEff, i + 1);
      wr(8'h04, 32'h0000_0000 | (i << 11));
      @(posedge clk);
      #1 chk(phaseTwoEff, (i < 1) ? 2 : i + 1);
    end
    wr(8'h04, 32'h0002_9901);
    waitHigh(1'b0, n);
    waitHigh(1'b0, n);
    chk(n, 20);
    waitHigh(1'b1, n);
    chk(n, 14);
    waitHigh(1'b0, n);
    chk(n, 6);
  endtask
  task automatic t_mode;
    wr(8'h00, 32'h0000_0000);
    waitMode(3'h0);
    chk(currentOpState, 3'h0);
    wr(8'h04, 32'h0000_0005);
    rd(8'h04);
    chk(rv, 32'h0002_9901);
    wr(8'h00, 32'h0500_0000);
    waitMode(3'h5);
    rd(8'h00);
    chk(rv, 32'h0500_0000);
    wr(8'h00, 32'h0400_0000);
    waitMode(3'h4);
    chk(currentOpState, 3'h4);
  endtask
  task automatic t_filter;
    wr(8'h08, 32'h7F3E_215A);
    wr(8'h08, 32'hFF3E_21DA);
    wr(8'h08, 32'h8000_0080);
    rd(8'h08);
    chk(rv, 32'hFF00_00DA);
    chk(fifoTarget, 20'hF_801A);
    chk({filterOn, maskChoice}, 12'h9C2);
    @(posedge clk);
    hitValid <= 1'b1;
    filterHit <= 4'hF;
    @(posedge clk);
    filterHit <= 4'h6;
    #1 chk({storeValid, storeFilter, storeMask, storeFifo}, 12'hC5A);
    @(posedge clk);
    filterHit <= 4'h8;
    #1 chk(storeValid, 1'b0);
    @(posedge clk);
    hitValid <= 1'b0;
    #1 chk({storeValid, storeFilter, storeMask, storeFifo}, 12'hDFF);
  endtask
  // two-cycle dominant glitch landing on the sample point only
  task automatic t_sample;
    for (int t = 0; t < 2; t++) begin
      wr(8'h04, 32'h0002_9903 | (t << 14));
      waitHigh(1'b0, n);
      waitHigh(1'b0, n);
      repeat (22) @(posedge clk);
      start <= 1'b1;
      lowLen <= 8'h02;
      @(posedge clk);
      start <= 1'b0;
      waitHigh(1'b1, n);
      @(posedge clk);
      #1 chk(sampledBit, t);
    end
  endtask
  task automatic pulse(input logic [7:0] len, input int exp);
    @(posedge clk);
    start <= 1'b1;
    lowLen <= len;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge clk);
      #1 n += (wakeEvent === 1'b1);
    end
    chk(n, exp);
  endtask
  initial begin
    rst = 1'b1;
    busReq = '0;
    hitValid = 1'b0;
    filterHit = 4'h0;
    start = 1'b0;
    lowLen = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_timing;
    t_mode;
    t_filter;
    pulse(8'h02, 1);
    wr(8'h04, 32'h0042_9901);
    pulse(8'h02, 0);
    pulse(8'h0C, 1);
    t_sample;
    finish_test;
  end
endmodule
bind cbf_top cbf_checker chk_i (.clk(clk), .rst(rst), .busReq(busReq),
  .rdData(rdData), .hitValid(hitValid), .filterHit(filterHit),
  .sampleStrobe(sampleStrobe), .bitBoundary(bitBoundary),
  .phaseTwoEff(phaseTwoEff), .currentOpState(currentOpState),
  .filterOn(filterOn), .maskChoice(maskChoice), .fifoTarget(fifoTarget),
  .storeValid(storeValid), .storeFifo(storeFifo),
  .storeFilter(storeFilter));
